// file: include/ppr_defs.svh
/*
  Constants of the process PID regulator: selector codes, scaling units,
  fixed-point layout and timing. Assumes a 10 MHz system clock.
*/
`ifndef PPR_DEFS_SVH
`define PPR_DEFS_SVH

// Reference selector codes
`define PPR_REF_DISABLED 4'h0
`define PPR_REF_EXCL_FIRST 4'h1
`define PPR_REF_EXCL_LAST 4'h4
`define PPR_REF_TRIM_FIRST 4'h5
`define PPR_REF_TRIM_LAST 4'h8

// Reference source index within a mode group
`define PPR_SRC_SETPOINT 2'h0
`define PPR_SRC_VOLTAGE 2'h1
`define PPR_SRC_CURRENT 2'h2
`define PPR_SRC_NETWORK 2'h3

// Feedback selector codes
`define PPR_FB_VOLTAGE 2'h0
`define PPR_FB_CURRENT 2'h1
`define PPR_FB_NETWORK 2'h2

// Percent values in 0.1 % steps; 100.0 % is this count
`define PPR_FULL_PCT 32'sd1000
// Network word: max frequency times ten is full scale
`define PPR_NET_SCALE 32'sd10
// Gain and rate settings carry two decimals
`define PPR_GAIN_UNIT 32'sd100
// Integral time setting in 0.1 s, expressed in milliseconds
`define PPR_TI_UNIT_MS 32'sd100
// Percent (0.1 %) times hertz over this gives 0.1 Hz
`define PPR_PCT_TO_DHZ 40'sd100
// Hertz to 0.1 Hz
`define PPR_HZ_TO_DHZ 32'sd10
// Fraction bits kept in the integral accumulator
`define PPR_INT_FRAC 8
// Saturation of the summed percentage
`define PPR_SUM_MAX 32'sd32767
`define PPR_SUM_MIN -32'sd32767

// Timing
`define PPR_CLK_PERIOD_NS 100
`define PPR_SAMPLE_TIME_NS 10000000
`define PPR_SAMPLE_TIME_MS (`PPR_SAMPLE_TIME_NS / 1000000)
`define PPR_SAMPLE_CYCLES (`PPR_SAMPLE_TIME_NS / `PPR_CLK_PERIOD_NS)

// Reset values
`define PPR_RESET_WORD 16'h0000
`define PPR_RESET_ACC 32'h0000_0000

`endif

// file: include/ppr_pkg.sv
/*
  Types of the process PID regulator: configuration bundle, process
  signal bundle and operating modes. Assumes ppr_defs.svh for numbers.
*/
package ppr_pkg;

  typedef enum logic [1:0] {
    PPR_MODE_OFF,
    PPR_MODE_EXCL,
    PPR_MODE_TRIM
  } ppr_mode_type;

  typedef struct packed {
    logic [3:0] reference_source_select;
    logic [1:0] feedback_source_select;
    logic [15:0] voltage_input_low_scale;   // 0.1 %
    logic [15:0] voltage_input_high_scale;  // 0.1 %
    logic [15:0] current_input_low_scale;   // 0.1 %
    logic [15:0] current_input_high_scale;  // 0.1 %
    logic error_sign_invert;
    logic [15:0] error_ignore_band;         // 0.1 %
    logic [15:0] integrator_start_value;    // Hz
    logic signed [15:0] trim_upper_limit;   // 0.1 Hz
    logic signed [15:0] trim_lower_limit;   // 0.1 Hz
    logic [15:0] proportional_factor;       // 0.01
    logic [15:0] integral_time_constant;    // 0.1 s
    logic [15:0] derivative_factor;         // 0.01
    logic [15:0] max_freq_hz;               // Hz
  } ppr_cfg_type;

  typedef struct packed {
    logic signed [15:0] voltage_in;  // 0.1 % of input span, may go negative
    logic [15:0] current_in;         // 0.1 % of 4-20 mA span
    logic [15:0] network_ref_word;
    logic [15:0] network_fb_word;
    logic [15:0] setpoint;           // 0.1 %
  } ppr_sig_type;

endpackage

// file: core/ppr_scaler.sv
/*
  Linear low/high scaler for one analog input, combinational.
  Assumes raw input and both scale settings in 0.1 % of full span.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ppr_defs.svh"

module ppr_scaler import ppr_pkg::*; #(
  parameter bit CLAMP_NEG = 1'b1  // Treat negative input as zero
) (
  input wire logic signed [15:0] raw_in,  // Input level
  input wire logic [15:0] low_scale,      // Input level giving 0 %
  input wire logic [15:0] high_scale,     // Input level giving 100 %
  output logic signed [15:0] scaled_out   // Result, 0.1 %
);

  logic signed [31:0] raw_c;
  logic signed [31:0] span;
  logic signed [31:0] prod;
  logic signed [31:0] quot;
  logic signed [31:0] sat;

  // Unipolar use only: a negative level reads as zero
  assign raw_c = (CLAMP_NEG && raw_in < 0) ? 32'sd0 : 32'(raw_in);
  // Low above high gives a falling span, inverting the map
  assign span = $signed({16'h0000, high_scale}) - $signed({16'h0000, low_scale});
  assign prod = (raw_c - $signed({16'h0000, low_scale})) * `PPR_FULL_PCT;
  // Equal ends would divide by zero; the output then rests at zero
  assign quot = (span == 0) ? 32'sd0 : prod / span;
  assign sat = (quot < 0) ? 32'sd0 : ((quot > `PPR_FULL_PCT) ? `PPR_FULL_PCT : quot);
  assign scaled_out = sat[15:0];

endmodule
`default_nettype wire

// file: core/ppr_regulator.sv
/*
  Process PID regulator: source selection, scaling, error with invert and
  deadband, preloaded integrator with anti-windup, and frequency command
  forming for exclusive and trim modes. Assumes synchronous inputs on mclk
  and a ramped speed reference supplied by the drive.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ppr_defs.svh"

// Overview of operation
// - Feedback from voltage, current or network input
// - Negative voltage input reads as zero
// - Network word: ten times max frequency equals full
// - Analog reference mapped linearly between low, high
// - Low above high inverts the mapping
// - Analog feedback uses the same scaling
// - Error invert setting negates error
// - Errors inside deadband are ignored
// - Start or enable preloads integrator frequency
// - Trim mode clamps output to trim limits
// - Integration freezes while output at limit
// - Proportional term is gain times error
// - Integral term accumulates error over time
// - Derivative term scales error change
// - Error equals reference minus feedback
// - Selector zero disables regulator
// - Exclusive mode zeroes speed reference
// - Trim mode adds output to speed reference
module ppr_regulator import ppr_pkg::*; #(
  parameter int unsigned SAMPLE_CYCLES = `PPR_SAMPLE_CYCLES  // Cycles per sample tick
) (
  input wire logic mclk,                         // System clock, 10 MHz
  input wire logic rst,                          // Synchronous reset, high
  input wire ppr_cfg_type cfg,                   // Configuration settings
  input wire ppr_sig_type sig,                   // Process signals
  input wire logic run_enable,                   // Drive running and loop enabled
  input wire logic signed [15:0] ramped_speed_ref, // Ramp output, 0.1 Hz
  output logic signed [15:0] freq_command_q,     // Frequency command, 0.1 Hz
  output logic signed [15:0] pid_output_q,       // Regulator output, 0.1 Hz
  output logic signed [15:0] speed_ref_to_ramp_q, // Speed reference into the ramp
  output logic ramp_bypass,                      // Regulator output skips the ramp
  output logic at_limit_q                        // Output sat at a limit last tick
);

  ////////////////////////////////////////////////////////////////////////
  // Mode and source decode

  ppr_mode_type mode;
  logic [1:0] ref_src;
  logic [3:0] rsel;
  assign rsel = cfg.reference_source_select;
  // Codes above the trim group are treated as disabled
  assign mode = (rsel >= `PPR_REF_TRIM_FIRST && rsel <= `PPR_REF_TRIM_LAST) ? PPR_MODE_TRIM :
                (rsel >= `PPR_REF_EXCL_FIRST && rsel <= `PPR_REF_EXCL_LAST) ? PPR_MODE_EXCL :
                PPR_MODE_OFF;
  assign ref_src = (mode == PPR_MODE_TRIM) ? 2'(rsel - `PPR_REF_TRIM_FIRST) :
                   2'(rsel - `PPR_REF_EXCL_FIRST);
  assign ramp_bypass = (mode == PPR_MODE_TRIM);

  ////////////////////////////////////////////////////////////////////////
  // Input scaling

  logic signed [15:0] volt_pct;
  logic signed [15:0] curr_pct;
  logic signed [31:0] maxhz;
  logic signed [31:0] net_ref_pct;
  logic signed [31:0] net_fb_pct;

  ppr_scaler #(.CLAMP_NEG(1'b1)) u_volt_scale (
    .raw_in(sig.voltage_in),
    .low_scale(cfg.voltage_input_low_scale),
    .high_scale(cfg.voltage_input_high_scale),
    .scaled_out(volt_pct)
  );

  ppr_scaler #(.CLAMP_NEG(1'b1)) u_curr_scale (
    .raw_in($signed(sig.current_in)),
    .low_scale(cfg.current_input_low_scale),
    .high_scale(cfg.current_input_high_scale),
    .scaled_out(curr_pct)
  );

  // A zero max frequency would divide by zero; it is read as 1 Hz
  assign maxhz = (cfg.max_freq_hz == 16'h0000) ? 32'sd1 : $signed({16'h0000, cfg.max_freq_hz});
  // Word / (max * 10) of full scale
  assign net_ref_pct = ($signed({16'h0000, sig.network_ref_word}) * `PPR_FULL_PCT) /
                       (maxhz * `PPR_NET_SCALE);
  assign net_fb_pct = ($signed({16'h0000, sig.network_fb_word}) * `PPR_FULL_PCT) /
                      (maxhz * `PPR_NET_SCALE);

  ////////////////////////////////////////////////////////////////////////
  // Reference, feedback and error

  logic signed [31:0] ref_pct;
  logic signed [31:0] fb_pct;
  logic signed [31:0] raw_err;
  logic signed [31:0] band;
  logic signed [31:0] band_err;
  logic signed [31:0] err;

  assign ref_pct = (ref_src == `PPR_SRC_SETPOINT) ? $signed({16'h0000, sig.setpoint}) :
                   (ref_src == `PPR_SRC_VOLTAGE) ? 32'(volt_pct) :
                   (ref_src == `PPR_SRC_CURRENT) ? 32'(curr_pct) : net_ref_pct;
  // Analog feedback goes through the same scalers as the reference
  assign fb_pct = (cfg.feedback_source_select == `PPR_FB_VOLTAGE) ? 32'(volt_pct) :
                  (cfg.feedback_source_select == `PPR_FB_CURRENT) ? 32'(curr_pct) :
                  net_fb_pct;
  assign raw_err = ref_pct - fb_pct;
  assign band = $signed({16'h0000, cfg.error_ignore_band});
  // Band is in absolute percent around the reference
  assign band_err = (raw_err <= band && raw_err >= -band) ? 32'sd0 : raw_err;
  assign err = cfg.error_sign_invert ? -band_err : band_err;

  ////////////////////////////////////////////////////////////////////////
  // Sample tick

  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain terms and limit

  logic act;
  logic act_q;
  logic start;
  logic signed [31:0] integ_q;
  logic signed [31:0] prev_err_q;
  logic signed [31:0] p_term;
  logic signed [31:0] i_inc;
  logic signed [31:0] d_term;
  logic signed [31:0] sum_pct;
  logic signed [31:0] sum_sat;
  logic signed [39:0] sum_dhz;
  logic signed [39:0] lim_hi;
  logic signed [39:0] lim_lo;
  logic signed [39:0] out_lim;
  logic limited;
  logic signed [31:0] preload_acc;
  logic signed [39:0] preload_dhz;

  assign act = run_enable && (mode != PPR_MODE_OFF);
  assign start = act && !act_q;
  // Factor 0.00 gives zero naturally
  assign p_term = (32'($signed({16'h0000, cfg.proportional_factor})) * err) / `PPR_GAIN_UNIT;
  // Zero integral time turns the term off rather than dividing by zero
  assign i_inc = (cfg.integral_time_constant == 16'h0000) ? 32'sd0 :
                 ((err * 32'(`PPR_SAMPLE_TIME_MS)) <<< `PPR_INT_FRAC) /
                 ($signed({16'h0000, cfg.integral_time_constant}) * `PPR_TI_UNIT_MS);
  assign d_term = ($signed({16'h0000, cfg.derivative_factor}) * (err - prev_err_q)) /
                  32'(`PPR_SAMPLE_TIME_MS);
  assign sum_pct = p_term + (integ_q >>> `PPR_INT_FRAC) + d_term;
  // Saturate so the product below cannot wrap
  assign sum_sat = (sum_pct > `PPR_SUM_MAX) ? `PPR_SUM_MAX :
                   ((sum_pct < `PPR_SUM_MIN) ? `PPR_SUM_MIN : sum_pct);
  assign sum_dhz = (40'(sum_sat) * 40'(maxhz)) / `PPR_PCT_TO_DHZ;
  // Exclusive mode is held to zero .. max frequency as a small safety net
  assign lim_hi = (mode == PPR_MODE_TRIM) ? 40'(cfg.trim_upper_limit) :
                  40'(maxhz * `PPR_HZ_TO_DHZ);
  assign lim_lo = (mode == PPR_MODE_TRIM) ? 40'(cfg.trim_lower_limit) : 40'sd0;
  assign limited = (sum_dhz >= lim_hi) || (sum_dhz <= lim_lo);
  assign out_lim = (sum_dhz > lim_hi) ? lim_hi : ((sum_dhz < lim_lo) ? lim_lo : sum_dhz);
  assign preload_acc = (($signed({16'h0000, cfg.integrator_start_value}) * `PPR_FULL_PCT) /
                        maxhz) <<< `PPR_INT_FRAC;
  assign preload_dhz = 40'($signed({16'h0000, cfg.integrator_start_value}) * `PPR_HZ_TO_DHZ);

  ////////////////////////////////////////////////////////////////////////
  // Regulator state

  // Preload wins over a tick landing on the same edge
  always_ff @(posedge mclk) begin
    if (rst || !act) begin
      act_q <= 1'b0;
      integ_q <= `PPR_RESET_ACC;
      prev_err_q <= `PPR_RESET_ACC;
      pid_output_q <= `PPR_RESET_WORD;
      at_limit_q <= 1'b0;
    end else if (start) begin
      act_q <= 1'b1;
      integ_q <= preload_acc;
      prev_err_q <= err;
      pid_output_q <= preload_dhz[15:0];
      at_limit_q <= 1'b0;
    end else if (tick) begin
      integ_q <= limited ? integ_q : integ_q + i_inc;
      prev_err_q <= err;
      pid_output_q <= out_lim[15:0];
      at_limit_q <= limited;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency command forming

  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_command_q <= `PPR_RESET_WORD;
      speed_ref_to_ramp_q <= `PPR_RESET_WORD;
    end else begin
      case (mode)
        PPR_MODE_EXCL: begin
          speed_ref_to_ramp_q <= `PPR_RESET_WORD;
          freq_command_q <= pid_output_q;
        end
        PPR_MODE_TRIM: begin
          speed_ref_to_ramp_q <= ramped_speed_ref;
          freq_command_q <= 16'(ramped_speed_ref + pid_output_q);
        end
        default: begin
          speed_ref_to_ramp_q <= ramped_speed_ref;
          freq_command_q <= ramped_speed_ref;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_off_passthru: assert property (@(posedge mclk) disable iff (rst)
    mode == PPR_MODE_OFF |=> freq_command_q == $past(ramped_speed_ref))
    else $error("disabled loop does not pass speed reference");
  chk_excl_zero_ref: assert property (@(posedge mclk) disable iff (rst)
    mode == PPR_MODE_EXCL |=> speed_ref_to_ramp_q == 16'sd0 &&
      freq_command_q == $past(pid_output_q))
    else $error("exclusive mode command wrong");
  chk_trim_sum: assert property (@(posedge mclk) disable iff (rst)
    mode == PPR_MODE_TRIM |=>
      freq_command_q == 16'($past(ramped_speed_ref) + $past(pid_output_q)))
    else $error("trim command is not reference plus output");
  chk_trim_clamp: assert property (@(posedge mclk) disable iff (rst)
    act && !start && tick && mode == PPR_MODE_TRIM |=>
      pid_output_q <= $past(cfg.trim_upper_limit) &&
      pid_output_q >= $past(cfg.trim_lower_limit))
    else $error("trim output outside limits");
  chk_windup_freeze: assert property (@(posedge mclk) disable iff (rst)
    act && act_q && tick && limited |=> integ_q == $past(integ_q))
    else $error("integrator moved at limit");
  chk_preload_load: assert property (@(posedge mclk) disable iff (rst)
    start ##1 act |-> integ_q == $past(preload_acc) && pid_output_q == $past(preload_dhz[15:0]))
    else $error("preload not applied at start");
  chk_deadband_zero: assert property (@(posedge mclk) disable iff (rst)
    raw_err <= band && raw_err >= -band |-> err == 32'sd0)
    else $error("error inside band not ignored");
  chk_invert_sign: assert property (@(posedge mclk) disable iff (rst)
    cfg.error_sign_invert |-> err == -band_err)
    else $error("inverted error has wrong sign");
  chk_integ_off: assert property (@(posedge mclk) disable iff (rst)
    act && act_q && tick && cfg.integral_time_constant == 16'h0000 |=> integ_q == $past(integ_q))
    else $error("integral term active with zero time");
  chk_tick_gap: assert property (@(posedge mclk) disable iff (rst)
    tick |=> !tick)
    else $error("sample ticks back to back");

endmodule
`default_nettype wire

// file: testbench/ppr_plant_model.sv
/*
  Process side of the regulator: sensor front ends and the drive ramp.
  Assumes the bench sets target levels; readings follow one mclk later.
*/
`timescale 1ns/1ns
`default_nettype none

module ppr_plant_model import ppr_pkg::*; (
  input wire logic mclk,                        // System clock
  input wire logic rst,                         // Synchronous reset, high
  input wire ppr_sig_type sig_target,           // Levels the sensors should report
  input wire logic signed [15:0] speed_target,  // Speed the ramp settles to
  output var ppr_sig_type sig,                  // Sensor readings
  output var logic signed [15:0] ramped_speed_ref  // Ramp output, 0.1 Hz
);
  // One cycle of converter latency; the ramp is taken as settled so that
  // trim results do not hang on ramp timing
  always_ff @(posedge mclk) begin
    if (rst) begin
      sig <= '0;
      ramped_speed_ref <= 16'sh0000;
    end else begin
      sig <= sig_target;
      ramped_speed_ref <= speed_target;
    end
  end
endmodule
`default_nettype wire

// file: testbench/ppr_regulator_test.sv
/*
  Self-checking bench for the process regulator.
  Assumes ppr_plant_model for sensors and ramp, and a short sample tick.
*/
`timescale 1ns/1ns
`default_nettype none

module ppr_regulator_test import ppr_pkg::*; ;
  localparam int SC = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run_enable = 1'b0;
  ppr_cfg_type cfg = '0;
  ppr_sig_type tgt = '0;
  logic signed [15:0] speed_target = 16'sh0000;
  ppr_sig_type sig;
  logic signed [15:0] ramped_speed_ref, freq_command_q, pid_output_q, speed_ref_to_ramp_q;
  logic ramp_bypass, at_limit_q;
  int miscompares = 0;
  int checks = 0;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  ppr_plant_model plant (.mclk(mclk), .rst(rst), .sig_target(tgt),
    .speed_target(speed_target), .sig(sig), .ramped_speed_ref(ramped_speed_ref));
  ppr_regulator #(.SAMPLE_CYCLES(SC)) dut (.mclk(mclk), .rst(rst), .cfg(cfg), .sig(sig),
    .run_enable(run_enable), .ramped_speed_ref(ramped_speed_ref),
    .freq_command_q(freq_command_q), .pid_output_q(pid_output_q),
    .speed_ref_to_ramp_q(speed_ref_to_ramp_q), .ramp_bypass(ramp_bypass),
    .at_limit_q(at_limit_q));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, $signed(exp), $signed(got));
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Drives change only at an edge; checks run 1 ns later once updates land
  task automatic restart();
    run_enable <= 1'b0;
    cyc(2);
    run_enable <= 1'b1;
    cyc(1);
    #1;
  endtask

  // Long enough for one full tick plus the command register behind it
  task automatic settle();
    cyc(SC + 3);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Exclusive or trim setup: gain 1.00, 50 Hz max, full-span scaling, wide trim
  function automatic ppr_cfg_type base(input logic [3:0] sel);
    ppr_cfg_type c;
    c = '0;
    c.reference_source_select = sel;
    c.voltage_input_high_scale = 16'h03E8;
    c.current_input_high_scale = 16'h03E8;
    c.proportional_factor = 16'h0064;
    c.max_freq_hz = 16'h0032;
    c.trim_upper_limit = 16'sh03E8;
    c.trim_lower_limit = -16'sh03E8;
    return c;
  endfunction

  function automatic ppr_sig_type lv(input logic signed [15:0] vin, input logic [15:0] cin,
      input logic [15:0] net, input logic [15:0] sp);
    ppr_sig_type s;
    s = '0;
    s.voltage_in = vin;
    s.current_in = cin;
    s.network_fb_word = net;
    s.setpoint = sp;
    return s;
  endfunction

  // Start fresh, wait a tick, then judge output, limit flag and command path
  task automatic run_case(input ppr_cfg_type c, input ppr_sig_type s, input int out,
      input logic lim);
    logic trim;
    trim = c.reference_source_select > 4'h4;
    cyc(1);
    cfg <= c;
    tgt <= s;
    restart();
    settle();
    chk("pid_output_q", 16'(out), pid_output_q);
    chk("at_limit_q", {15'h0000, lim}, {15'h0000, at_limit_q});
    chk("freq_command_q", 16'(trim ? 123 + out : out), freq_command_q);
    chk("ramp_bypass", {15'h0000, trim}, {15'h0000, ramp_bypass});
    chk("speed_ref_to_ramp_q", 16'(trim ? 123 : 0), speed_ref_to_ramp_q);
  endtask

  // Setpoint 50.0 %, gain 1.00, 50 Hz: output in 0.1 Hz is (500 - fb) / 2
  task automatic fb_case(input logic [1:0] sel, input logic signed [15:0] vin,
      input logic [15:0] cin, net, vhi, clo, chi, input int fb);
    ppr_cfg_type c;
    c = base(4'h1);
    c.feedback_source_select = sel;
    c.voltage_input_high_scale = vhi;
    c.current_input_low_scale = clo;
    c.current_input_high_scale = chi;
    run_case(c, lv(vin, cin, net, 16'h01F4), (500 - fb) * 50 / 100, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    #1;
    chk("pid_output_q", 16'h0000, pid_output_q);
    chk("freq_command_q", 16'h0000, freq_command_q);
    cyc(1);
    speed_target <= 16'sh007B;
    run_enable <= 1'b1;
    cyc(3);
    #1;
    chk("freq_command_q", 16'h007B, freq_command_q);
    chk("pid_output_q", 16'h0000, pid_output_q);
    $display("test reset_and_off done");
  endtask

  task automatic t_preload();
    ppr_cfg_type c;
    c = base(4'h1);
    c.proportional_factor = 16'h0000;
    c.integrator_start_value = 16'h001E;
    cyc(1);
    cfg <= c;
    tgt <= lv(16'sh0000, 16'h0000, 16'h0000, 16'h0000);
    restart();
    chk("pid_output_q", 16'h012C, pid_output_q);
    cyc(1);
    #1;
    chk("freq_command_q", 16'h012C, freq_command_q);
    chk("speed_ref_to_ramp_q", 16'h0000, speed_ref_to_ramp_q);
    $display("test preload done");
  endtask

  task automatic t_feedback();
    fb_case(2'h0, 16'sh00C8, 16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 200);
    fb_case(2'h1, 16'sh0000, 16'h00C8, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 200);
    fb_case(2'h2, 16'sh0000, 16'h0000, 16'h0064, 16'h03E8, 16'h0000, 16'h03E8, 200);
    fb_case(2'h0, -16'sh0064, 16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 0);
    fb_case(2'h0, 16'sh0064, 16'h0000, 16'h0000, 16'h01F4, 16'h0000, 16'h03E8, 200);
    fb_case(2'h1, 16'sh0000, 16'h0320, 16'h0000, 16'h03E8, 16'h03E8, 16'h0000, 200);
    $display("test feedback done");
  endtask

  // Reference from the voltage, current and network sources in exclusive mode, and from voltage in trim mode
  task automatic t_refsrc();
    ppr_cfg_type c;
    ppr_sig_type s;
    c = base(4'h2);
    c.feedback_source_select = 2'h1;
    c.voltage_input_high_scale = 16'h01F4;
    run_case(c, lv(16'sh00C8, 16'h00C8, 16'h0000, 16'h0000), 100, 1'b0);
    c = base(4'h3);
    run_case(c, lv(16'sh00C8, 16'h02BC, 16'h0000, 16'h0000), 250, 1'b0);
    c = base(4'h4);
    c.feedback_source_select = 2'h1;
    s = lv(16'sh0000, 16'h00C8, 16'h0000, 16'h0000);
    s.network_ref_word = 16'h00C8;
    run_case(c, s, 100, 1'b0);
    c = base(4'h6);
    c.feedback_source_select = 2'h1;
    run_case(c, lv(16'sh0258, 16'h00C8, 16'h0000, 16'h0000), 200, 1'b0);
    $display("test reference_source done");
  endtask

  // Error of +30.0 % from setpoint 500 and voltage feedback 200
  task automatic t_error();
    ppr_cfg_type c;
    ppr_sig_type s;
    s = lv(16'sh00C8, 16'h0000, 16'h0000, 16'h01F4);
    c = base(4'h1);
    c.error_ignore_band = 16'h012C;
    run_case(c, s, 0, 1'b1);
    c.error_ignore_band = 16'h012B;
    run_case(c, s, 150, 1'b0);
    c = base(4'h5);
    c.error_sign_invert = 1'b1;
    run_case(c, s, -150, 1'b0);
    c.trim_upper_limit = 16'sh0064;
    c.trim_lower_limit = -16'sh0032;
    run_case(c, s, -50, 1'b1);
    c.error_sign_invert = 1'b0;
    run_case(c, s, 100, 1'b1);
    $display("test error_and_trim done");
  endtask

  // Ti 2.0 s at 100 % error: 0.5 % of 100 Hz per 10 ms tick, 5 counts of 0.1 Hz
  task automatic t_integral();
    ppr_cfg_type c;
    logic signed [15:0] first;
    c = base(4'h1);
    c.proportional_factor = 16'h0000;
    c.integral_time_constant = 16'h0014;
    c.integrator_start_value = 16'h000A;
    c.max_freq_hz = 16'h0064;
    cyc(1);
    cfg <= c;
    tgt <= lv(16'sh0000, 16'h0000, 16'h0000, 16'h03E8);
    restart();
    chk("pid_output_q", 16'h0064, pid_output_q);
    settle();
    first = pid_output_q;
    cyc(SC);
    #1;
    chk("pid_output_q", first + 16'sh0005, pid_output_q);
    $display("test integral done");
  endtask

  // Rate 1.00 and an error step of -1.0 %: one tick of -10.0 %, then gone
  task automatic t_deriv();
    ppr_cfg_type c;
    int n;
    c = base(4'h1);
    c.proportional_factor = 16'h0000;
    c.derivative_factor = 16'h0064;
    c.integrator_start_value = 16'h0014;
    cyc(1);
    cfg <= c;
    tgt <= lv(16'sh01F4, 16'h0000, 16'h0000, 16'h01F4);
    restart();
    settle();
    chk("pid_output_q", 16'h00C8, pid_output_q);
    cyc(1);
    tgt <= lv(16'sh01FE, 16'h0000, 16'h0000, 16'h01F4);
    #1;
    n = 0;
    // Bounded wait: the step must show within two ticks
    while (pid_output_q === 16'sh00C8 && n < 2 * SC) begin
      cyc(1);
      #1;
      n++;
    end
    if (n >= 2 * SC) begin
      miscompares++;
      $display("CHECK FAILED pid_output_q expected change seen none");
      test_done();
    end
    chk("pid_output_q", 16'h0096, pid_output_q);
    cyc(SC);
    #1;
    chk("pid_output_q", 16'h00C8, pid_output_q);
    $display("test derivative done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held four cycles, then every scenario in turn
  initial begin
    cyc(4);
    rst <= 1'b0;
    t_reset();
    t_preload();
    t_feedback();
    t_refsrc();
    t_error();
    t_integral();
    t_deriv();
    test_done();
  end
endmodule
`default_nettype wire
